// ==== mirb_check_properties.sv ====
// Checker on the answer port of the input register bank.
// Assumes the bank keeps its default map revision.
`timescale 1ns/1ns
module mirb_check
  import mirb_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire mirb_req_type   req,
  input wire mirb_rtc_type   rtc,
  input wire mirb_press_type press,
  input wire mirb_rsp_type   rsp
);
  logic        rd;
  logic [15:0] a;
  assign rd = req.valid && req.func == MIRB_FC_READ_INPUT;
  assign a  = req.addr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_answer_next: assert property (
    req.valid |=> rsp.valid) else $error("no answer");
  a_quiet_idle: assert property (
    !req.valid |=> rsp == '0) else $error("output not idle");
  a_bad_func: assert property (
    req.valid && !rd |=> rsp.exc_code == MIRB_EXC_ILL_FUNC)
    else $error("bad function accepted");
  a_bad_addr: assert property (
    rd && a > 16'h12 |=> rsp.exception && rsp.exc_code == MIRB_EXC_ILL_ADDR)
    else $error("bad address accepted");
  a_revision_min: assert property (
    rd && a == 16'h0 |=> rsp.data >= MIRB_REV_LOWEST) else $error("low rev");
  a_clock_month: assert property (
    rd && a == 16'h1 |=> rsp.data == $past(rtc.month)) else $error("month");
  a_angle_bits: assert property (
    rd && a == 16'h9 |=> rsp.data == ($past(press.angle_binary) & 16'hFFFC))
    else $error("resolver angle");
  a_motor_flag: assert property (
    rd && a == 16'hD |=> (rsp.data != 16'h0) == $past(press.motor_running))
    else $error("motor flag");
  a_reserved_zero: assert property (
    rd && (a == 16'h7 || a == 16'hC) |=> !rsp.exception && rsp.data == '0)
    else $error("reserved not zero");
endmodule : mirb_check
bind mirb_input_register_bank mirb_check mirb_check_i (.clk(clk),
  .rst_n(rst_n), .req(req), .rtc(rtc), .press(press), .rsp(rsp));

// ==== mirb_input_register_bank.sv ====
// Read-only input register bank answering one register read per request.
// Assumes the framing layer splits multi-register reads into single words
// and forms exception frames from the exception code it is handed.
`timescale 1ns/1ns

// Behaviour
// [RL1] Bank is read-only; only function 0x04 reads, returning 16-bit words.
// [RL2] Address 0 returns the implemented register map revision.
// [RL3] Revision value is raised whenever parameters are added to the map.
// [RL4] Lowest revision reported is 1.08, encoded as 108.
// [RL5] Addresses 1 to 6 return month, day, year, hour, minute, second.
// [RL6] Address 8 returns crank angle in degrees times 100.
// [RL7] Address 9 returns binary resolver angle, two low bits zero.
// [RL8] Address 10 returns flywheel speed in RPM, where available.
// [RL9] Address 11 returns crankshaft speed in RPM.
// [RL10] Address 13 is non-zero while the motor runs, else zero.
// [RL11] Address 14 is non-zero while the clutch is engaged, else zero.
// [RL12] Address 15 returns 1 when guard control engaged, 0 when not.
// [RL13] Address 16 returns auxiliary message selector from parallel port.
// [RL14] Address 17 returns stroking mode code 0 to 19.
// [RL15] Address 18 is non-zero when key switch is in mode select.
// [RL16] Reserved addresses 7 and 12 read zero without exception.
module mirb_input_register_bank
  import mirb_pkg::*;
#(
  parameter logic [15:0] MAP_REVISION = MIRB_REV_DEFAULT
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire mirb_req_type   req,
  input  wire mirb_rtc_type   rtc,
  input  wire mirb_press_type press,
  output mirb_rsp_type        rsp
);

  // [RL4] Revision floor
  // Elaboration refuses a map revision older than the first one shipped.
  if (MAP_REVISION < MIRB_REV_LOWEST) begin : g_rev_check
    $error("map revision below lowest supported value");
  end

  // Answer fields, one flop each; the port is their concatenation
  logic         valid_ff;
  logic         exception_ff;
  logic [7:0]   exc_code_ff;
  logic [15:0]  data_ff;

  // Next values of the answer fields
  logic         nxt_valid;
  logic         nxt_exception;
  logic [7:0]   nxt_exc_code;
  logic [15:0]  nxt_data;

  // Decode of the request now on the port
  logic         func_ok;
  logic         addr_ok;
  logic         rtc_hit;
  logic [15:0]  rtc_word;
  logic [15:0]  press_word;
  logic [15:0]  read_word;

  // Map end must cover the last register the decode serves
  if (MIRB_ADR_LAST < MIRB_ADR_KEY_SW) begin : g_map_check
    $error("map end below last register");
  end

  // The data field of the answer port is one 16-bit word
  if (MIRB_DATA_W != 16) begin : g_word_check
    $error("word width must be 16");
  end

  // Addresses arrive as whole 16-bit words from the framing layer
  if (MIRB_ADDR_W != 16) begin : g_addr_check
    $error("address width must be 16");
  end

  // Flags would read the same either way if these collided
  if (MIRB_FLAG_ON == MIRB_ZERO) begin : g_flag_check
    $error("flag encodings collide");
  end

  // Resolver mask must clear the two low bits
  if (MIRB_ANG_BIN_MASK[1:0] != 2'h0) begin : g_mask_check
    $error("resolver mask keeps low bits");
  end

  // Flags widen to a whole word: true reads 1, false reads 0
  function automatic logic [15:0] mirb_flag(input logic level);
    mirb_flag = level ? MIRB_FLAG_ON : MIRB_ZERO;
  endfunction : mirb_flag

  // [RL1] Function filter
  // Only the input read code is served; nothing here is writable
  function automatic logic mirb_func_ok(input logic [7:0] func);
    mirb_func_ok = (func == MIRB_FC_READ_INPUT);
  endfunction : mirb_func_ok

  // Address range of the bank; the framing layer never offsets it
  function automatic logic mirb_addr_ok(input logic [15:0] addr);
    mirb_addr_ok = (addr <= MIRB_ADR_LAST);
  endfunction : mirb_addr_ok

  // Clock fields occupy one contiguous run of addresses
  function automatic logic mirb_is_rtc(input logic [15:0] addr);
    mirb_is_rtc = (addr >= MIRB_ADR_MONTH) && (addr <= MIRB_ADR_SECOND);
  endfunction : mirb_is_rtc

  // [RL14] Stroking mode widening
  // Codes above the range pass unchanged; the source owns validity
  function automatic logic [15:0] mirb_mode_word(input logic [4:0] mode);
    mirb_mode_word = {11'h000, mode};
  endfunction : mirb_mode_word

  // A bad function outranks a bad address
  function automatic logic [7:0] mirb_refusal(
    input logic fn_ok,
    input logic ad_ok
  );
    mirb_refusal = MIRB_EXC_NONE;
    case ({fn_ok, ad_ok})
      2'h3: begin
        mirb_refusal = MIRB_EXC_NONE;
      end
      2'h2: begin
        mirb_refusal = MIRB_EXC_ILL_ADDR;
      end
      default: begin
        mirb_refusal = MIRB_EXC_ILL_FUNC;
      end
    endcase
  endfunction : mirb_refusal

  // [RL5] Clock fields
  function automatic logic [15:0] mirb_rtc_word(
    input mirb_rtc_type time_in,
    input logic [15:0]  addr
  );
    mirb_rtc_word = MIRB_ZERO;
    case (addr)
      MIRB_ADR_MONTH: begin
        mirb_rtc_word = time_in.month;
      end

      MIRB_ADR_DAY: begin
        mirb_rtc_word = time_in.day;
      end

      MIRB_ADR_YEAR: begin
        mirb_rtc_word = time_in.year;
      end

      MIRB_ADR_HOUR: begin
        mirb_rtc_word = time_in.hour;
      end

      MIRB_ADR_MINUTE: begin
        mirb_rtc_word = time_in.minute;
      end

      MIRB_ADR_SECOND: begin
        mirb_rtc_word = time_in.second;
      end

      default: begin
        mirb_rtc_word = MIRB_ZERO;
      end
    endcase
  endfunction : mirb_rtc_word

  // Machine words; reserved slots read zero
  function automatic logic [15:0] mirb_press_word(
    input mirb_press_type p,
    input logic [15:0]    addr
  );
    mirb_press_word = MIRB_ZERO;
    case (addr)
      // [RL16] Reserved reads zero
      MIRB_ADR_RSVD_A: begin
        mirb_press_word = MIRB_ZERO;
      end

      // [RL6] Scaled angle
      MIRB_ADR_ANG_SCALE: begin
        mirb_press_word = p.angle_scaled;
      end

      // [RL7] Resolver angle masked
      // Low bits forced clear so a finer resolver never leaks noise
      MIRB_ADR_ANG_BIN: begin
        mirb_press_word = p.angle_binary & MIRB_ANG_BIN_MASK;
      end

      // [RL8] Flywheel speed
      // Reads zero on systems without a drive speed source
      MIRB_ADR_FLY_SPEED: begin
        mirb_press_word = p.flywheel_rpm;
      end

      // [RL9] Crankshaft speed
      MIRB_ADR_CRK_SPEED: begin
        mirb_press_word = p.crankshaft_rpm;
      end

      // [RL16] Reserved reads zero
      MIRB_ADR_RSVD_B: begin
        mirb_press_word = MIRB_ZERO;
      end

      // [RL10] Motor flag
      MIRB_ADR_MOTOR: begin
        mirb_press_word = mirb_flag(p.motor_running);
      end

      // [RL11] Clutch flag
      MIRB_ADR_CLUTCH: begin
        mirb_press_word = mirb_flag(p.clutch_engaged);
      end

      // [RL12] Guard state
      MIRB_ADR_GUARD: begin
        mirb_press_word = mirb_flag(p.guard_control);
      end

      // [RL13] Selector passthrough
      MIRB_ADR_AUX_SEL: begin
        mirb_press_word = p.aux_selector;
      end

      // [RL14] Stroking mode
      MIRB_ADR_STROKE: begin
        mirb_press_word = mirb_mode_word(p.stroking_mode);
      end

      // [RL15] Key switch
      MIRB_ADR_KEY_SW: begin
        mirb_press_word = mirb_flag(p.mode_key_switch);
      end

      default: begin
        mirb_press_word = MIRB_ZERO;
      end
    endcase
  endfunction : mirb_press_word

  // Address decode of the live inputs; each read sees current values
  always_comb begin
    func_ok = mirb_func_ok(req.func);
  end

  always_comb begin
    addr_ok = mirb_addr_ok(req.addr);
  end

  always_comb begin
    rtc_hit = mirb_is_rtc(req.addr);
  end

  // Both word sources decode in parallel; the address picks one
  always_comb begin
    rtc_word = mirb_rtc_word(rtc, req.addr);
  end

  always_comb begin
    press_word = mirb_press_word(press, req.addr);
  end

  // [RL2] Revision readout
  // [RL3] Raised via parameter
  always_comb begin
    read_word = press_word;
    if (req.addr == MIRB_ADR_REVISION) begin
      read_word = MAP_REVISION;
    end else if (rtc_hit) begin
      read_word = rtc_word;
    end
  end

  // Every request is answered on the next edge; there is no busy state
  always_comb begin
    nxt_valid = req.valid;
  end

  // Refused when either the function or the address is out of reach
  always_comb begin
    nxt_exception = 1'b0;
    if (req.valid) begin
      nxt_exception = !func_ok || !addr_ok;
    end
  end

  // [RL1] Refusal codes
  always_comb begin
    nxt_exc_code = MIRB_EXC_NONE;
    if (req.valid) begin
      nxt_exc_code = mirb_refusal(func_ok, addr_ok);
    end
  end

  // Data stays zero on a refusal or with no request, so idle reads clean
  always_comb begin
    nxt_data = MIRB_RST_DATA;
    if (req.valid && func_ok && addr_ok) begin
      nxt_data = read_word;
    end
  end

  // Answer strobe, one cycle per request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // Refusal marker
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exception_ff <= 1'b0;
    end else begin
      exception_ff <= nxt_exception;
    end
  end

  // Refusal code
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exc_code_ff <= MIRB_EXC_NONE;
    end else begin
      exc_code_ff <= nxt_exc_code;
    end
  end

  // Register word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_ff <= MIRB_RST_DATA;
    end else begin
      data_ff <= nxt_data;
    end
  end

  // Port fields come straight from their flops
  assign rsp = '{valid_ff, exception_ff, exc_code_ff, data_ff};

endmodule : mirb_input_register_bank

// ==== mirb_input_register_bank_tb.sv ====
// Testbench: reads every input register, then refused requests.
// Assumes each read is answered one clock later.
`timescale 1ns/1ns
module mirb_input_register_bank_tb;
  import mirb_pkg::*;
  logic           clk;
  logic           rst_n;
  mirb_req_type   req;
  mirb_rtc_type   rtc;
  mirb_press_type press;
  mirb_rsp_type   rsp;
  logic [24:0]    q[$];
  logic [24:0]    seen;
  logic [7:0]     funcs[4] = '{8'h01, 8'h03, 8'h06, 8'h10};
  int             fail_count = 0;
  int             n_checks = 0;
  int             seed = 61;
  mirb_master mirb_master_i (.clk(clk), .req(req));
  mirb_input_register_bank mirb_input_register_bank_i (.clk(clk),
    .rst_n(rst_n), .req(req), .rtc(rtc), .press(press), .rsp(rsp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [24:0] exp_rsp(logic [7:0] f, logic [15:0] a);
    logic [15:0] d;
    d = 16'h0;
    if (f != MIRB_FC_READ_INPUT) return {1'b1, MIRB_EXC_ILL_FUNC, 16'h0};
    if (a > 16'h12) return {1'b1, MIRB_EXC_ILL_ADDR, 16'h0};
    case (a)
      16'h0: d = 16'h006C;
      16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6: d = 16'(rtc >> (16 * (6 - a)));
      16'h8: d = press.angle_scaled;
      16'h9: d = press.angle_binary & 16'hFFFC;
      16'hA: d = press.flywheel_rpm;
      16'hB: d = press.crankshaft_rpm;
      16'hD: d = 16'(press.motor_running);
      16'hE: d = 16'(press.clutch_engaged);
      16'hF: d = 16'(press.guard_control);
      16'h10: d = press.aux_selector;
      16'h11: d = 16'(press.stroking_mode);
      16'h12: d = 16'(press.mode_key_switch);
      default: ;
    endcase
    return {1'b0, MIRB_EXC_NONE, d};
  endfunction : exp_rsp
  task automatic check(logic [24:0] s, logic [24:0] e);
    n_checks++;
    if (s !== e) begin
      $display("BAD %0t response mismatch", $time);
      fail_count++;
    end
  endtask : check
  // Fresh random inputs each read, so flags take both values
  task automatic rd(logic [7:0] f, logic [15:0] a);
    rtc = {$random(seed), $random(seed), $random(seed)};
    press = 89'({$random(seed), $random(seed), $random(seed)});
    q.push_back(exp_rsp(f, a));
    mirb_master_i.read(f, a);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  always @(negedge clk) begin
    if (rsp.valid !== 1'b0) begin
      seen = q.size() > 0 ? q.pop_front() : 'x;
      check({rsp.exception, rsp.exc_code, rsp.data}, seen);
    end
  end
  initial begin
    rst_n = 1'b0;
    rtc = '0;
    press = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    repeat (3) for (int a = 0; a < 21; a++) rd(8'h04, 16'(a));
    foreach (funcs[i]) begin
      rd(funcs[i], 16'($random(seed)));
      mirb_master_i.idle();
    end
    rd(8'h04, 16'hFFFF);
    mirb_master_i.idle();
    repeat (3) @(negedge clk);
    stop_test();
  end
  initial begin
    #2000;
    fail_count++;
    stop_test();
  end
endmodule : mirb_input_register_bank_tb

// ==== mirb_master.sv ====
// Stand-in for the remote master: one word read per call.
// Assumes callers enter its tasks just after a falling edge.
`timescale 1ns/1ns
module mirb_master
  import mirb_pkg::*;
(
  input  wire logic   clk,
  output mirb_req_type req
);
  initial req = '0;
  task automatic read(input logic [7:0] f, input logic [15:0] a);
    req <= '{1'b1, f, a};
    @(negedge clk);
  endtask : read
  // Released lines flip, so stale values never pass
  task automatic idle();
    req <= '{1'b0, ~req.func, ~req.addr};
    @(negedge clk);
  endtask : idle
endmodule : mirb_master

// ==== mirb_pkg.sv ====
// Constants and carrier types for the read-only input register bank.
// Assumes a Modbus framing layer outside that decodes requests per word.
package mirb_pkg;

  localparam int          MIRB_DATA_W        = 16;
  localparam int          MIRB_ADDR_W        = 16;

  // Function code on the request port and exception codes on the answer port
  localparam logic [7:0]  MIRB_FC_READ_INPUT = 8'h04;
  localparam logic [7:0]  MIRB_EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  MIRB_EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0]  MIRB_EXC_NONE      = 8'h00;

  // Map revision, hundredths: 1.08 reads as 108
  localparam logic [15:0] MIRB_REV_DEFAULT   = 16'h006C;
  localparam logic [15:0] MIRB_REV_LOWEST    = 16'h006C;

  // Register addresses
  localparam logic [15:0] MIRB_ADR_REVISION  = 16'h0000;
  localparam logic [15:0] MIRB_ADR_MONTH     = 16'h0001;
  localparam logic [15:0] MIRB_ADR_DAY       = 16'h0002;
  localparam logic [15:0] MIRB_ADR_YEAR      = 16'h0003;
  localparam logic [15:0] MIRB_ADR_HOUR      = 16'h0004;
  localparam logic [15:0] MIRB_ADR_MINUTE    = 16'h0005;
  localparam logic [15:0] MIRB_ADR_SECOND    = 16'h0006;
  localparam logic [15:0] MIRB_ADR_RSVD_A    = 16'h0007;
  localparam logic [15:0] MIRB_ADR_ANG_SCALE = 16'h0008;
  localparam logic [15:0] MIRB_ADR_ANG_BIN   = 16'h0009;
  localparam logic [15:0] MIRB_ADR_FLY_SPEED = 16'h000A;
  localparam logic [15:0] MIRB_ADR_CRK_SPEED = 16'h000B;
  localparam logic [15:0] MIRB_ADR_RSVD_B    = 16'h000C;
  localparam logic [15:0] MIRB_ADR_MOTOR     = 16'h000D;
  localparam logic [15:0] MIRB_ADR_CLUTCH    = 16'h000E;
  localparam logic [15:0] MIRB_ADR_GUARD     = 16'h000F;
  localparam logic [15:0] MIRB_ADR_AUX_SEL   = 16'h0010;
  localparam logic [15:0] MIRB_ADR_STROKE    = 16'h0011;
  localparam logic [15:0] MIRB_ADR_KEY_SW    = 16'h0012;
  localparam logic [15:0] MIRB_ADR_LAST      = 16'h0012;

  // Field layout and values
  localparam logic [15:0] MIRB_ANG_BIN_MASK  = 16'hFFFC;
  localparam logic [15:0] MIRB_FLAG_ON       = 16'h0001;
  localparam logic [15:0] MIRB_ZERO          = 16'h0000;
  localparam logic [4:0]  MIRB_STROKE_MAX    = 5'h13;

  // Reset values of the answer port
  localparam logic [15:0] MIRB_RST_DATA      = 16'h0000;

  typedef struct packed {
    logic [15:0] month;
    logic [15:0] day;
    logic [15:0] year;
    logic [15:0] hour;
    logic [15:0] minute;
    logic [15:0] second;
  } mirb_rtc_type;

  typedef struct packed {
    logic [15:0] angle_scaled;
    logic [15:0] angle_binary;
    logic [15:0] flywheel_rpm;
    logic [15:0] crankshaft_rpm;
    logic        motor_running;
    logic        clutch_engaged;
    logic        guard_control;
    logic [15:0] aux_selector;
    logic [4:0]  stroking_mode;
    logic        mode_key_switch;
  } mirb_press_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [15:0] addr;
  } mirb_req_type;

  typedef struct packed {
    logic        valid;
    logic        exception;
    logic [7:0]  exc_code;
    logic [15:0] data;
  } mirb_rsp_type;

endpackage : mirb_pkg
